/* File: src/dual_pot_serial_command_decoder.sv */
// Serial command decoder with two wiper registers and a nonvolatile store
`timescale 1ns/1ps
`include "pot_defines.svh"
module dual_pot_serial_command_decoder
    import pot_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic                serialClk,
    input  wire logic                serialInPin,
    input  wire logic                chipSelect_n,
    input  wire logic                writeProtect_n,
    input  wire logic                presetStrobePin_n,
    output logic                     serialOutPinOut,
    output logic                     serialOutPinOe,
    output logic [`WIPER_W-1:0]      wiperRegister0,
    output logic [`WIPER_W-1:0]      wiperRegister1,
    output logic                     lowPowerState,
    output logic                     readProgramState
);
    import pot_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        phase_t                               phase;
        logic [`WORD_W-1:0]                   shiftReg;
        logic                                 outBit;
        logic                                 outOe;
        logic                                 sclkPrev;
        logic                                 csPrev;
        logic                                 presetPrev;
        logic [`CHAN_COUNT-1:0][`WIPER_W-1:0] wiper;
        logic [`STORE_DEPTH-1:0][`WIPER_W-1:0] store;
        logic                                 readProgram;
        logic                                 lowPower;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    logic [`SYNC_W-1:0] pinsSync;
    logic               sclkSync;
    logic               sdiSync;
    logic               csSync_n;
    logic               wpSync_n;
    logic               presetSync_n;

    sync_two_flop #(
        .WIDTH (`SYNC_W)
    ) u_sync (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .asyncIn    ({serialClk, serialInPin, chipSelect_n, writeProtect_n,
                      presetStrobePin_n}),
        .resetLevel ({`SYNC_W{1'b1}}),
        .syncOut    (pinsSync)
    );

    assign sclkSync     = pinsSync[4];
    assign sdiSync      = pinsSync[3];
    assign csSync_n     = pinsSync[2];
    assign wpSync_n     = pinsSync[1];
    assign presetSync_n = pinsSync[0];

    // ****************************************************************
    // Edge detection and word fields
    // ****************************************************************
    logic                  sclkRise;
    logic                  sclkFall;
    logic                  csRise;
    logic                  csFall;
    logic                  presetRise;
    logic                  presetLow;
    logic                  execute;
    command_t              cmd;
    logic [3:0]            addr;
    logic [`WIPER_W-1:0]   dataByte;
    logic                  chan;
    logic                  wpActive;

    // Link clock is sampled, so SPI edges are only seen while selected
    assign sclkRise   = !csSync_n && sclkSync && !st.sclkPrev;
    assign sclkFall   = !csSync_n && !sclkSync && st.sclkPrev;
    assign csRise     = csSync_n && !st.csPrev;
    assign csFall     = !csSync_n && st.csPrev;
    assign presetLow  = !presetSync_n;
    assign presetRise = presetSync_n && !st.presetPrev;
    assign execute    = csRise && (st.phase == PHASE_RUN);

    // Last sixteen bits shifted in form the word
    assign cmd      = command_t'(st.shiftReg[`CMD_MSB:`CMD_LSB]);
    assign addr     = st.shiftReg[`ADDR_MSB:`ADDR_LSB];
    assign dataByte = st.shiftReg[`DATA_MSB:`DATA_LSB];
    assign chan     = st.shiftReg[`CHAN_BIT];
    assign wpActive = !wpSync_n;

    // ****************************************************************
    // Per-channel operation decode
    // ****************************************************************
    function automatic alu_op_t decodeOp(
        input command_t c,
        input logic     sel,
        input logic     addrIsZero,
        input logic     protect
    );
        alu_op_t op;
        op = ALU_HOLD;
        unique case (c)
            CMD_RECALL_ONE: op = sel ? ALU_LOAD : ALU_HOLD;
            CMD_SHR_ONE:    op = sel ? ALU_SHR : ALU_HOLD;
            CMD_SHR_ALL:    op = ALU_SHR;
            CMD_DEC_ONE:    op = sel ? ALU_DEC : ALU_HOLD;
            CMD_DEC_ALL:    op = ALU_DEC;
            CMD_RELOAD_ALL: op = addrIsZero ? ALU_LOAD : ALU_HOLD;
            CMD_LOAD_WIPER: op = sel ? ALU_LOAD : ALU_HOLD;
            CMD_SHL_ONE:    op = sel ? ALU_SHL : ALU_HOLD;
            CMD_SHL_ALL:    op = ALU_SHL;
            CMD_INC_ONE:    op = sel ? ALU_INC : ALU_HOLD;
            CMD_INC_ALL:    op = ALU_INC;
            default:        op = ALU_HOLD;
        endcase
        // Only the reload command may move a protected wiper
        if (protect && c != CMD_RELOAD_ALL) begin
            op = ALU_HOLD;
        end
        return op;
    endfunction : decodeOp

    alu_op_t                              aluOp     [`CHAN_COUNT];
    logic [`CHAN_COUNT-1:0][`WIPER_W-1:0] aluLoad;
    logic [`CHAN_COUNT-1:0][`WIPER_W-1:0] aluResult;
    logic                                 applyWiper;

    // Preset and power-on refresh take priority over serial commands
    assign applyWiper = execute || presetLow || presetRise || (st.phase == PHASE_INIT);

    genvar ch;
    generate
        for (ch = 0; ch < `CHAN_COUNT; ch++) begin : g_chan
            always_comb begin
                if (st.phase == PHASE_INIT || presetRise) begin
                    aluOp[ch]   = ALU_LOAD;
                    aluLoad[ch] = st.store[ch];
                end else if (presetLow) begin
                    aluOp[ch]   = ALU_LOAD;
                    aluLoad[ch] = `WIPER_MID;
                end else begin
                    aluOp[ch]   = decodeOp(cmd, chan == 1'(ch), addr == `ADDR_ZERO,
                                           wpActive);
                    // Data byte only reaches the direct load; others ignore it
                    aluLoad[ch] = (cmd == CMD_LOAD_WIPER) ? dataByte
                                                          : st.store[ch];
                end
            end

            wiper_alu u_alu (
                .value     (st.wiper[ch]),
                .op        (aluOp[ch]),
                .loadValue (aluLoad[ch]),
                .result    (aluResult[ch])
            );
        end
    endgenerate

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st            = st;
        next_st.phase      = PHASE_RUN;
        next_st.sclkPrev   = sclkSync;
        next_st.csPrev     = csSync_n;
        next_st.presetPrev = presetSync_n;

        if (applyWiper) begin
            next_st.wiper = aluResult;
        end

        // Shift in on rising link clock edges, MSB first
        if (sclkRise) begin
            next_st.shiftReg = {st.shiftReg[`WORD_W-2:0], sdiSync};
        end

        // Output changes on falling edge, first bit at select
        if (csFall || sclkFall) begin
            next_st.outBit = st.shiftReg[`WORD_W-1];
        end

        if (execute) begin
            unique case (cmd)
                CMD_NO_OPERATION: begin
                    next_st.lowPower    = 1'b1;
                    next_st.readProgram = 1'b0;
                end
                CMD_RECALL_ONE: begin
                    next_st.readProgram = 1'b1;
                    next_st.lowPower    = 1'b0;
                end
                CMD_SAVE_ONE: begin
                    next_st.store[{3'b000, chan}] = st.wiper[chan];
                    next_st.lowPower              = 1'b0;
                end
                CMD_WRITE_STORE: begin
                    next_st.store[addr] = dataByte;
                    next_st.lowPower    = 1'b0;
                end
                CMD_READ_STORE: begin
                    next_st.shiftReg[`DATA_MSB:`DATA_LSB] = st.store[addr];
                    next_st.lowPower                      = 1'b0;
                end
                CMD_READ_WIPER: begin
                    next_st.shiftReg[`DATA_MSB:`DATA_LSB] = st.wiper[chan];
                    next_st.lowPower                      = 1'b0;
                end
                default: begin
                    next_st.lowPower = 1'b0;
                end
            endcase
        end

        // Open drain: pull low only while selected and the bit is zero
        next_st.outOe = !csSync_n && !next_st.outBit;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st.phase       <= PHASE_INIT;
            st.shiftReg    <= `WORD_RESET;
            st.outBit      <= 1'b1;
            st.outOe       <= 1'b0;
            st.sclkPrev    <= 1'b1;
            st.csPrev      <= 1'b1;
            st.presetPrev  <= 1'b1;
            st.wiper       <= {`CHAN_COUNT{`WIPER_MID}};
            st.store       <= `STORE_RESET;
            st.readProgram <= 1'b0;
            st.lowPower    <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign serialOutPinOut  = 1'b0 & st.outBit;
    assign serialOutPinOe   = st.outOe;
    assign wiperRegister0   = st.wiper[0];
    assign wiperRegister1   = st.wiper[1];
    assign lowPowerState    = st.lowPower;
    assign readProgramState = st.readProgram;

endmodule : dual_pot_serial_command_decoder

/* File: src/pot_defines.svh */
// Constants for the dual wiper serial command decoder
`ifndef POT_DEFINES_SVH
`define POT_DEFINES_SVH

// ****************************************************************
// Word layout
// ****************************************************************
`define WORD_W          16
`define CMD_MSB         15
`define CMD_LSB         12
`define ADDR_MSB        11
`define ADDR_LSB        8
`define DATA_MSB        7
`define DATA_LSB        0
`define CHAN_BIT        8
`define WORD_RESET      16'h0000

// ****************************************************************
// Wiper values and storage
// ****************************************************************
`define WIPER_W         8
`define WIPER_ZERO      8'h00
`define WIPER_ONE       8'h01
`define WIPER_MID       8'h80
`define WIPER_FULL      8'hFF
`define STORE_DEPTH     16
`define STORE_RESET     {16{8'h80}}
`define ADDR_ZERO       4'h0
`define CHAN_COUNT      2
`define SYNC_W          5

`endif

/* File: src/pot_pkg.sv */
// Types shared by the dual wiper serial command decoder
package pot_pkg;

    typedef enum logic [3:0] {
        CMD_NO_OPERATION = 4'h0,
        CMD_RECALL_ONE   = 4'h1,
        CMD_SAVE_ONE     = 4'h2,
        CMD_WRITE_STORE  = 4'h3,
        CMD_SHR_ONE      = 4'h4,
        CMD_SHR_ALL      = 4'h5,
        CMD_DEC_ONE      = 4'h6,
        CMD_DEC_ALL      = 4'h7,
        CMD_RELOAD_ALL   = 4'h8,
        CMD_READ_STORE   = 4'h9,
        CMD_READ_WIPER   = 4'hA,
        CMD_LOAD_WIPER   = 4'hB,
        CMD_SHL_ONE      = 4'hC,
        CMD_SHL_ALL      = 4'hD,
        CMD_INC_ONE      = 4'hE,
        CMD_INC_ALL      = 4'hF
    } command_t;

    typedef enum logic [2:0] {
        ALU_HOLD = 3'b000,
        ALU_INC  = 3'b001,
        ALU_DEC  = 3'b010,
        ALU_SHL  = 3'b011,
        ALU_SHR  = 3'b100,
        ALU_LOAD = 3'b101
    } alu_op_t;

    typedef enum logic [0:0] {
        PHASE_INIT = 1'b0,
        PHASE_RUN  = 1'b1
    } phase_t;

endpackage : pot_pkg

/* File: src/sync_two_flop.sv */
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`include "pot_defines.svh"
module sync_two_flop #(
    parameter int WIDTH = `SYNC_W
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    input  wire logic [WIDTH-1:0] resetLevel,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st.first  = asyncIn;
        next_st.second = st.first;
    end

    // Reset loads all ones; resetLevel cancels out of syncOut and has no effect
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign syncOut = st.second ^ ~resetLevel ^ ~resetLevel;

endmodule : sync_two_flop

/* File: src/wiper_alu.sv */
// Saturating step, shift and load arithmetic for one wiper channel
`timescale 1ns/1ps
`include "pot_defines.svh"
module wiper_alu
    import pot_pkg::*;
(
    input  wire logic [`WIPER_W-1:0] value,
    input  wire pot_pkg::alu_op_t    op,
    input  wire logic [`WIPER_W-1:0] loadValue,
    output logic      [`WIPER_W-1:0] result
);
    always_comb begin
        unique case (op)
            ALU_INC: result = (value == `WIPER_FULL) ? value : value + `WIPER_ONE;
            ALU_DEC: result = (value == `WIPER_ZERO) ? value : value - `WIPER_ONE;
            ALU_SHL: begin
                if (value == `WIPER_ZERO) begin
                    result = `WIPER_ONE;
                end else if (value >= `WIPER_MID) begin
                    result = `WIPER_FULL;
                end else begin
                    result = {value[`WIPER_W-2:0], 1'b0};
                end
            end
            ALU_SHR: result = {1'b0, value[`WIPER_W-1:1]};
            ALU_LOAD: result = loadValue;
            default: result = value;
        endcase
    end

endmodule : wiper_alu

/* File: testbench/dual_pot_checker_assertions.sv */
// Port-level assertions for the dual wiper serial command decoder
`timescale 1ns/1ps
`include "pot_defines.svh"
module dual_pot_checker
    import pot_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                reset_n,
    input wire logic                serialClk,
    input wire logic                serialInPin,
    input wire logic                chipSelect_n,
    input wire logic                writeProtect_n,
    input wire logic                presetStrobePin_n,
    input wire logic                serialOutPinOut,
    input wire logic                serialOutPinOe,
    input wire logic [`WIPER_W-1:0] wiperRegister0,
    input wire logic [`WIPER_W-1:0] wiperRegister1,
    input wire logic                lowPowerState,
    input wire logic                readProgramState
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_oe_idle_off: assert property (chipSelect_n [*6] |-> !serialOutPinOe)
        else $error("serial output driven while deselected");
    a_od_drive_low: assert property (serialOutPinOe |-> !serialOutPinOut)
        else $error("open drain output drives high");
    // Eight samples leave room for the synchroniser and the execute latency
    a_busy_wipers_hold: assert property ((!chipSelect_n && presetStrobePin_n) [*8]
        |-> $stable(wiperRegister0) && $stable(wiperRegister1))
        else $error("wiper changed while a word was shifting in");
    a_idle_wipers_hold: assert property ((chipSelect_n && presetStrobePin_n) [*8]
        |-> $stable(wiperRegister0) && $stable(wiperRegister1))
        else $error("wiper changed with no command pending");
    a_preset_mid: assert property (!presetStrobePin_n [*6]
        |-> wiperRegister0 == `WIPER_MID && wiperRegister1 == `WIPER_MID)
        else $error("wipers not at midscale during preset");
    a_state_exclusive: assert property (!(lowPowerState && readProgramState))
        else $error("low power and read program states both set");
    a_rest_states: assert property (!chipSelect_n [*8]
        |-> $stable(lowPowerState) && $stable(readProgramState))
        else $error("power state changed while a word was shifting in");
    a_reset_values: assert property ($rose(reset_n) |-> wiperRegister0 == `WIPER_MID
        && wiperRegister1 == `WIPER_MID && lowPowerState && !readProgramState)
        else $error("wrong state after reset release");

    c_read_program: cover property ($rose(readProgramState));
    c_wiper_full: cover property (wiperRegister0 == `WIPER_FULL);
    c_preset_held: cover property (!presetStrobePin_n [*6]);
    c_readback_out: cover property ($rose(serialOutPinOe));
endmodule : dual_pot_checker

bind dual_pot_serial_command_decoder dual_pot_checker u_checker (
    .core_clk(core_clk), .reset_n(reset_n), .serialClk(serialClk),
    .serialInPin(serialInPin), .chipSelect_n(chipSelect_n), .writeProtect_n(writeProtect_n),
    .presetStrobePin_n(presetStrobePin_n), .serialOutPinOut(serialOutPinOut),
    .serialOutPinOe(serialOutPinOe), .wiperRegister0(wiperRegister0),
    .wiperRegister1(wiperRegister1), .lowPowerState(lowPowerState),
    .readProgramState(readProgramState)
);

/* File: testbench/spi_master_model.sv */
// Behavioural SPI master that frames words into the decoder
`timescale 1ns/1ps
module spi_master_model (
    input  wire logic core_clk,
    input  wire logic lineLevel,
    input  wire logic idleHigh,
    output logic      serialClk,
    output logic      serialInPin,
    output logic      chipSelect_n
);
    logic [31:0] rxWord;
    event        frameEnd;

    initial begin
        serialClk    = 1'b0;
        serialInPin  = 1'b1;
        chipSelect_n = 1'b1;
        rxWord       = 32'h00000000;
    end

    // ****************************************************************
    // Mode 0 or 3 frame: data moves on falling edges, sampled on rising
    // ****************************************************************
    task automatic send(input logic [31:0] bits, input int n);
        @(negedge core_clk);
        rxWord       = 32'h00000000;
        // Idle level settles before select, so no false first edge
        serialClk    = idleHigh;
        #32 chipSelect_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            if (idleHigh) begin
                #32 serialClk = 1'b0;
            end
            serialInPin = bits[i];
            #32 serialClk = 1'b1;
            rxWord = {rxWord[30:0], lineLevel};
            if (!idleHigh) begin
                #32 serialClk = 1'b0;
            end
        end
        #32 chipSelect_n = 1'b1;
        // Released line shows the inverse so a stale level never looks valid
        serialInPin = ~serialInPin;
        -> frameEnd;
        #64;
    endtask : send
endmodule : spi_master_model

/* File: testbench/dual_pot_serial_command_decoder_tb_top.sv */
// Self-checking bench for the dual wiper serial command decoder
`timescale 1ns/1ps
`include "pot_defines.svh"
module dual_pot_serial_command_decoder_tb_top;
    import pot_pkg::*;
    typedef struct {logic [31:0] rx; logic [7:0] w0; logic [7:0] w1; logic lp; logic rp;} note_t;

    logic                core_clk;
    logic                reset_n;
    logic                writeProtect_n;
    logic                presetStrobePin_n;
    logic                serialClk;
    logic                serialInPin;
    logic                chipSelect_n;
    logic                serialOutPinOut;
    logic                serialOutPinOe;
    logic                lineLevel;
    logic                spiIdleHigh;
    logic [`WIPER_W-1:0] wiperRegister0;
    logic [`WIPER_W-1:0] wiperRegister1;
    logic                lowPowerState;
    logic                readProgramState;
    logic [7:0]          w [2];
    logic [7:0]          st [16];
    logic [15:0]         sr;
    logic                lp;
    logic                rp;
    logic [31:0]         rnd;
    note_t               q [$];
    int                  mismatches;
    int                  compares;
    logic [11:0]         corners [10] = '{12'h400, 12'h600, 12'hC00, 12'hEFF, 12'hC80,
                                          12'hC7F, 12'hDFF, 12'h700, 12'h501, 12'h481};
    logic [15:0]         wpSeq [6] = '{16'hB155, 16'hE000, 16'h3077, 16'h8000, 16'h9000,
                                       16'h0000};

    // Pull-up on the open-drain line
    assign lineLevel = serialOutPinOe ? serialOutPinOut : 1'b1;

    dual_pot_serial_command_decoder dut (
        .core_clk(core_clk), .reset_n(reset_n), .serialClk(serialClk),
        .serialInPin(serialInPin), .chipSelect_n(chipSelect_n),
        .writeProtect_n(writeProtect_n), .presetStrobePin_n(presetStrobePin_n),
        .serialOutPinOut(serialOutPinOut), .serialOutPinOe(serialOutPinOe),
        .wiperRegister0(wiperRegister0), .wiperRegister1(wiperRegister1),
        .lowPowerState(lowPowerState), .readProgramState(readProgramState)
    );
    spi_master_model master (
        .core_clk(core_clk), .lineLevel(lineLevel), .idleHigh(spiIdleHigh),
        .serialClk(serialClk),
        .serialInPin(serialInPin), .chipSelect_n(chipSelect_n)
    );

    // ****************************************************************
    // Reference model
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] step(input logic [7:0] v, input logic [3:0] c);
        case (c)
            4'h4:    return v >> 1;
            4'h6:    return (v == 8'h00) ? v : v - 8'h01;
            4'hC:    return (v == 8'h00) ? 8'h01 : (v >= 8'h80) ? 8'hFF : v << 1;
            default: return (v == 8'hFF) ? v : v + 8'h01;
        endcase
    endfunction : step

    // Group commands take any address; reload only with address zero
    function automatic logic [3:0] pick_addr(input logic [3:0] c, input logic [3:0] a);
        if (c == 4'h8) return 4'h0;
        if (c == 4'h3 || c == 4'h9 || (c[0] && c[2])) return a;
        return {3'b000, a[0]};
    endfunction : pick_addr

    task automatic exec_word(input logic [15:0] wd);
        logic [3:0] c;
        logic [3:0] s;
        logic       ch;
        c  = wd[15:12];
        s  = c - 4'h1;
        ch = wd[8];
        lp = (c == 4'h0);
        if (c == 4'h0) rp = 1'b0;
        if (c == 4'h1) rp = 1'b1;
        case (c)
            4'h1: if (writeProtect_n) w[ch] = st[ch];
            4'h2: st[ch] = w[ch];
            4'h3: st[wd[11:8]] = wd[7:0];
            4'h8: w = '{st[0], st[1]};
            4'h9: sr[7:0] = st[wd[11:8]];
            4'hA: sr[7:0] = w[ch];
            4'hB: if (writeProtect_n) w[ch] = wd[7:0];
            4'h4, 4'h6, 4'hC, 4'hE: if (writeProtect_n) w[ch] = step(w[ch], c);
            4'h5, 4'h7, 4'hD, 4'hF: if (writeProtect_n) w = '{step(w[0], s), step(w[1], s)};
            default: ;
        endcase
    endtask : exec_word

    // ****************************************************************
    // Drivers and checks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic check_state(input logic [7:0] w0, w1, input logic l, r);
        check("wiper 0", {24'h0, wiperRegister0}, {24'h0, w0});
        check("wiper 1", {24'h0, wiperRegister1}, {24'h0, w1});
        check("low power", {31'h0, lowPowerState}, {31'h0, l});
        check("read program", {31'h0, readProgramState}, {31'h0, r});
    endtask : check_state

    // Output bits are the old shift register, then the incoming bits
    task automatic frame(input logic [31:0] bits, input int n);
        note_t       nt;
        logic [47:0] seq;
        seq = {sr, bits << (32 - n)};
        nt.rx = seq[47:16] >> (32 - n);
        sr = bits[15:0];
        exec_word(bits[15:0]);
        nt.w0 = w[0];
        nt.w1 = w[1];
        nt.lp = lp;
        nt.rp = rp;
        q.push_back(nt);
        master.send(bits, n);
    endtask : frame

    task automatic send_cmd(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d);
        frame({16'h0000, c, a, d}, 16);
    endtask : send_cmd

    task automatic do_reset();
        @(negedge core_clk);
        reset_n = 1'b0;
        w = '{8'h80, 8'h80};
        foreach (st[i]) st[i] = 8'h80;
        sr = 16'h0000;
        lp = 1'b1;
        rp = 1'b0;
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check_state(8'h80, 8'h80, 1'b1, 1'b0);
    endtask : do_reset

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin : monitor
        note_t nt;
        forever begin
            @(master.frameEnd);
            repeat (8) @(posedge core_clk);
            #1;
            nt = q.pop_front();
            check("serial out word", master.rxWord, nt.rx);
            check_state(nt.w0, nt.w1, nt.lp, nt.rp);
        end
    end

    initial begin : watchdog
        repeat (80000) @(posedge core_clk);
        mismatches++;
        report_and_stop();
    end

    initial begin : main
        reset_n           = 1'b0;
        writeProtect_n    = 1'b1;
        presetStrobePin_n = 1'b1;
        spiIdleHigh       = 1'b0;
        mismatches        = 0;
        compares          = 0;
        rnd               = 32'h0D1D1CB0;
        do_reset();
        for (int c = 0; c < 16; c++) begin
            rnd = lfsr(rnd);
            send_cmd(c[3:0], pick_addr(c[3:0], rnd[11:8]), rnd[7:0]);
            send_cmd(4'hA, {3'b000, rnd[16]}, rnd[31:24]);
        end
        foreach (corners[i]) begin
            send_cmd(4'hB, {3'b000, i[0]}, corners[i][7:0]);
            send_cmd(corners[i][11:8], {3'b000, i[0]}, 8'hA5);
        end
        @(negedge core_clk);
        writeProtect_n = 1'b0;
        foreach (wpSeq[i]) send_cmd(wpSeq[i][15:12], wpSeq[i][11:8], wpSeq[i][7:0]);
        @(negedge core_clk);
        writeProtect_n    = 1'b1;
        presetStrobePin_n = 1'b0;
        repeat (10) @(negedge core_clk);
        check_state(8'h80, 8'h80, lp, rp);
        presetStrobePin_n = 1'b1;
        w = '{st[0], st[1]};
        repeat (10) @(negedge core_clk);
        check_state(w[0], w[1], lp, rp);
        frame(32'h005AB1C3, 24);
        frame(32'hC3E0E1FF, 32);
        spiIdleHigh = 1'b1;
        repeat (40) begin
            rnd = lfsr(rnd);
            send_cmd(rnd[15:12], pick_addr(rnd[15:12], rnd[11:8]), rnd[7:0]);
        end
        send_cmd(4'h0, 4'h0, 8'h00);
        do_reset();
        send_cmd(4'hA, 4'h1, 8'h00);
        send_cmd(4'h0, 4'h0, 8'h00);
        for (int i = 0; i < 100 && q.size() != 0; i++) @(posedge core_clk);
        if (q.size() != 0) mismatches++;
        report_and_stop();
    end
endmodule : dual_pot_serial_command_decoder_tb_top
